//--- ubcp_pkg.sv
// Package with register map, field layouts and reset values of the baud/polarity block
package ubcp_pkg;
  localparam logic [7:0] ADDR_DIV_LOW = 8'h00;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_DSPEED_BIT = 2;
  localparam int CTRL_LEGACY_BIT = 3;
  localparam int DIV_W = 12;
  localparam int DIV_HIGH_W = 4;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- ubcp_prescaler.sv
// Baud prescaler: down counter reloaded from the divisor, one tick per wrap
`timescale 1ns/1ps
module ubcp_prescaler #(
  parameter int DIV_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [DIV_W-1:0] divisor_i,
  input wire logic reload_i,
  output logic tick_o
);
  logic [DIV_W-1:0] count;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (reload_i) begin
      count <= divisor_i;
    end else if (count == '0) begin
      count <= divisor_i;
    end else begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !reload_i && (count == '0);
    end
  end

  a_tick_on_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!reload_i && count == '0) |=> tick_o)
    else $error("prescaler wrap without tick");
  a_reload_loads: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reload_i |=> (count == $past(divisor_i)) && !tick_o)
    else $error("prescaler not reloaded");
endmodule // ubcp_prescaler

//--- ubcp_top.sv
// Baud divisor registers, speed selection and synchronous clock polarity with AXI4-Lite access
// Operation
// - Sync polarity 0: transmit changes on rising, receive samples on falling; 1 swaps.
// - Divisor is twelve bits: high register gives top four, low register bottom eight.
// - Writing the low byte reloads the prescaler immediately with the new divisor.
// - Legacy compatibility mode makes the high divisor register inaccessible.
// - Asynchronous double speed changes ticks per bit from sixteen to eight.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module ubcp_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_clock_pin_i,
  input wire logic serial_in_pin_i,
  input wire logic tx_next_bit_i,
  output logic serial_out_pin_o,
  output logic rx_sample_o,
  output logic rx_sample_bit_o,
  output logic tx_shift_o,
  output logic bit_tick_o,
  output logic baud_tick_o
);
  logic [7:0] div_low;
  logic [3:0] div_high;
  logic [3:0] ctrl;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic wr_ok;
  logic low_wr;
  logic [11:0] divisor;
  logic [11:0] next_divisor;
  logic [4:0] ovs_count;
  logic [2:0] xck_sync;
  logic [2:0] rxd_sync;
  logic rxd_level;
  logic xck_level;
  logic xck_rise;
  logic xck_fall;
  logic tx_edge;
  logic rx_edge;
  logic sync_mode;

  assign sync_mode = ctrl[ubcp_pkg::CTRL_SYNC_BIT];
  assign divisor = {div_high, div_low};

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = (aw_addr == ubcp_pkg::ADDR_DIV_LOW) || (aw_addr == ubcp_pkg::ADDR_CTRL) ||
    (aw_addr == ubcp_pkg::ADDR_STATUS) ||
    (aw_addr == ubcp_pkg::ADDR_DIV_HIGH && !ctrl[ubcp_pkg::CTRL_LEGACY_BIT]);
  assign low_wr = wr_fire && aw_addr == ubcp_pkg::ADDR_DIV_LOW && w_strb[0];
  // Reload must see the byte being written, not the stale register
  assign next_divisor = low_wr ? {div_high, w_data[7:0]} : divisor;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ubcp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ubcp_pkg::RESP_OKAY : ubcp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_low <= ubcp_pkg::DIV_RESET[7:0];
      div_high <= ubcp_pkg::DIV_RESET[11:8];
      ctrl <= ubcp_pkg::CTRL_RESET;
    end else if (wr_fire && wr_ok && w_strb[0]) begin
      case (aw_addr)
        ubcp_pkg::ADDR_DIV_LOW: div_low <= w_data[7:0];
        // Reserved upper bits are dropped; legacy mode blocks the write
        ubcp_pkg::ADDR_DIV_HIGH: div_high <= w_data[3:0];
        ubcp_pkg::ADDR_CTRL: ctrl <= w_data[3:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ubcp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ubcp_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        ubcp_pkg::ADDR_DIV_LOW: s_axi_rdata <= {24'h000000, div_low};
        ubcp_pkg::ADDR_DIV_HIGH: begin
          s_axi_rdata <= ctrl[ubcp_pkg::CTRL_LEGACY_BIT] ? 32'h0000_0000 : {28'h0000000, div_high};
          s_axi_rresp <= ctrl[ubcp_pkg::CTRL_LEGACY_BIT] ? ubcp_pkg::RESP_SLVERR : ubcp_pkg::RESP_OKAY;
        end
        ubcp_pkg::ADDR_CTRL: s_axi_rdata <= {28'h0000000, ctrl};
        ubcp_pkg::ADDR_STATUS: s_axi_rdata <= {29'h0, xck_level, rxd_level, serial_out_pin_o};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ubcp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ubcp_prescaler #(
    .DIV_W(ubcp_pkg::DIV_W)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .divisor_i(next_divisor),
    .reload_i(low_wr),
    .tick_o(baud_tick_o)
  );

  // Oversampling divider: 16 normally, 8 with double speed in async mode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovs_count <= 5'h00;
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= 1'b0;
      if (low_wr) begin
        ovs_count <= 5'h00;
      end else if (baud_tick_o) begin
        if (ovs_count >= ((ctrl[ubcp_pkg::CTRL_DSPEED_BIT] && !sync_mode) ?
            ubcp_pkg::OVS_DOUBLE : ubcp_pkg::OVS_NORMAL) - 5'h01) begin
          ovs_count <= 5'h00;
          bit_tick_o <= 1'b1;
        end else begin
          ovs_count <= ovs_count + 5'h01;
        end
      end
    end
  end

  // Pin inputs: three stages, change counted once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xck_sync <= 3'b000;
      rxd_sync <= 3'b111;
      xck_level <= 1'b0;
      rxd_level <= 1'b1;
    end else begin
      xck_sync <= {xck_sync[1:0], sync_clock_pin_i};
      rxd_sync <= {rxd_sync[1:0], serial_in_pin_i};
      if (xck_sync[1] == xck_sync[2]) begin
        xck_level <= xck_sync[2];
      end
      if (rxd_sync[1] == rxd_sync[2]) begin
        rxd_level <= rxd_sync[2];
      end
    end
  end

  assign xck_rise = (xck_sync[1] == xck_sync[2]) && xck_sync[2] && !xck_level;
  assign xck_fall = (xck_sync[1] == xck_sync[2]) && !xck_sync[2] && xck_level;
  // Polarity ignored in async mode, so a stale setting cannot misalign edges
  assign tx_edge = ctrl[ubcp_pkg::CTRL_POL_BIT] ? xck_fall : xck_rise;
  assign rx_edge = ctrl[ubcp_pkg::CTRL_POL_BIT] ? xck_rise : xck_fall;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_out_pin_o <= 1'b1;
      tx_shift_o <= 1'b0;
      rx_sample_o <= 1'b0;
      rx_sample_bit_o <= 1'b1;
    end else begin
      tx_shift_o <= sync_mode && tx_edge;
      rx_sample_o <= sync_mode && rx_edge;
      if (sync_mode && tx_edge) begin
        serial_out_pin_o <= tx_next_bit_i;
      end else if (!sync_mode && bit_tick_o) begin
        serial_out_pin_o <= tx_next_bit_i;
      end
      if (sync_mode && rx_edge) begin
        rx_sample_bit_o <= rxd_level;
      end
    end
  end

  a_pol0_tx_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sync_mode && !ctrl[ubcp_pkg::CTRL_POL_BIT] && xck_rise) |=> tx_shift_o && !rx_sample_o)
    else $error("polarity 0 transmit edge wrong");
  a_pol1_rx_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sync_mode && ctrl[ubcp_pkg::CTRL_POL_BIT] && xck_rise) |=> rx_sample_o && !tx_shift_o)
    else $error("polarity 1 receive edge wrong");
  a_div_compose: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_fire && wr_ok && w_strb[0] && aw_addr == ubcp_pkg::ADDR_DIV_HIGH) |=>
    divisor[11:8] == $past(w_data[3:0]) && divisor[7:0] == $past(div_low))
    else $error("divisor high nibble not stored");
  a_legacy_block: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_fire && ctrl[ubcp_pkg::CTRL_LEGACY_BIT] && aw_addr == ubcp_pkg::ADDR_DIV_HIGH) |=>
    $stable(div_high) && s_axi_bresp == ubcp_pkg::RESP_SLVERR)
    else $error("legacy mode high register written");
  a_low_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    low_wr |=> !baud_tick_o ##1 ovs_count == 5'h00)
    else $error("low write did not restart prescaler");
  a_double_speed: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (baud_tick_o && !low_wr && ctrl[ubcp_pkg::CTRL_DSPEED_BIT] && !sync_mode) |=>
    ovs_count <= 5'h07)
    else $error("double speed divider exceeded eight");
endmodule // ubcp_top

//--- ubcp_line_model.sv
// Line-side partner model: drives the synchronous clock and the receive line
`timescale 1ns/1ps
module ubcp_line_model (
  input wire logic clk_i,
  input wire logic serial_out_pin_i,
  output logic sync_clock_pin_o,
  output logic serial_in_pin_o
);
  // Clock stands still between edges; line idles high
  initial begin
    sync_clock_pin_o = 1'b0;
    serial_in_pin_o = 1'b1;
  end
  // One clock edge, data set up span cycles ahead; larger span is a slow partner
  task automatic clock_edge(input logic lvl, input logic b, input int span, output logic tx_line);
    @(posedge clk_i);
    serial_in_pin_o <= b;
    repeat (span) @(posedge clk_i);
    sync_clock_pin_o <= lvl;
    repeat (span + 6) @(posedge clk_i);
    tx_line = serial_out_pin_i;
    // Hold over: inverse value so a late sample shows up
    serial_in_pin_o <= ~b;
  endtask
endmodule // ubcp_line_model

//--- tb.sv
// Self-checking testbench for the baud divisor and clock polarity block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] LO = ubcp_pkg::ADDR_DIV_LOW;
  localparam logic [7:0] HI = ubcp_pkg::ADDR_DIV_HIGH;
  localparam logic [7:0] CT = ubcp_pkg::ADDR_CTRL;
  localparam logic [1:0] OK = ubcp_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ubcp_pkg::RESP_SLVERR;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic tx_bit = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sclk, sin, sout, rxs, rxb, txs, bitt, baudt, tx_seen, rx_seen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_fail = 0, tests_run = 0, cyc = 0, n_tx = 0, n_rx = 0, seed = 90460;
  always #4 clk_i = ~clk_i;
  ubcp_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync_clock_pin_i(sclk),
    .serial_in_pin_i(sin), .tx_next_bit_i(tx_bit), .serial_out_pin_o(sout), .rx_sample_o(rxs),
    .rx_sample_bit_o(rxb), .tx_shift_o(txs), .bit_tick_o(bitt), .baud_tick_o(baudt));
  ubcp_line_model partner (.clk_i(clk_i), .serial_out_pin_i(sout), .sync_clock_pin_o(sclk), .serial_in_pin_o(sin));
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (txs) begin
      n_tx <= n_tx + 1;
      tx_seen <= sout;
    end
    if (rxs) begin
      n_rx <= n_rx + 1;
      rx_seen <= rxb;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count assumed; the watchdog ends a hung wait
    forever begin
      @(posedge clk_i);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk("rresp", er, rresp);
    if (e !== 32'hx) chk("rdata", e, rdata);
  endtask
  task automatic wait_pulse(input logic which);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk_i);
      if (which ? bitt : baudt) break;
    end
    if (k == 1000) begin
      n_fail++;
      $display("unexpected pulse wait: expected %0d seen %0d", 1, 0);
    end
  endtask
  // Full interval only: the first pulse after a change may close a partial one
  task automatic gap(input logic which, output int g);
    int t0;
    wait_pulse(which);
    t0 = cyc;
    wait_pulse(which);
    g = cyc - t0;
  endtask
  function automatic int bit_span(input logic [31:0] c, input int d);
    return ((c[2] && !c[0]) ? ubcp_pkg::OVS_DOUBLE : ubcp_pkg::OVS_NORMAL) * (d + 1);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    int d, g, t0, a, r;
    logic [31:0] c;
    logic b, lvl, tl;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(LO, 32'h0, OK);
    rd(HI, 32'h0, OK);
    rd(CT, 32'h0, OK);
    rd(ubcp_pkg::ADDR_STATUS, 32'h3, OK);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hfff : $random(seed) & 32'hfff;
      wr(HI, d >> 8, OK);
      wr(LO, d & 32'hff, OK);
      rd(LO, d & 32'hff, OK);
      rd(HI, d >> 8, OK);
    end
    wr(HI, 32'h0, OK);
    for (int i = 0; i < 3; i++) begin
      d = (i < 2) ? i : 2 + ($unsigned($random(seed)) % 8);
      wr(LO, 32'hff, OK);
      wr(LO, d, OK);
      t0 = cyc;
      wait_pulse(1'b0);
      chk("reload wait", d + 1, cyc - t0);
      gap(1'b0, g);
      chk("baud period", d + 1, g);
    end
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 32'h0 : (i == 1) ? 32'h4 : 32'h5;
      wr(CT, c, OK);
      gap(1'b1, g);
      chk("bit period", bit_span(c, d), g);
    end
    wr(CT, 32'h8, OK);
    wr(HI, 32'h3, ER);
    rd(HI, 32'h0, ER);
    wr(CT, 32'h0, OK);
    rd(HI, 32'h0, OK);
    wr(8'h10, 32'h5a, ER);
    rd(8'h10, 32'hx, ER);
    for (int p = 0; p < 2; p++) begin
      wr(CT, 32'h1 | (p << 1), OK);
      for (int e = 0; e < 2; e++) begin
        lvl = (e == 0);
        b = 1'($random(seed));
        @(posedge clk_i);
        tx_bit <= ~b;
        a = n_tx;
        r = n_rx;
        partner.clock_edge(lvl, b, 4 + 8 * p, tl);
        chk("tx shifts", a + (lvl ^ p), n_tx);
        chk("rx samples", r + !(lvl ^ p), n_rx);
        if (lvl ^ p) chk("tx line", 1'(~b), tx_seen);
        else chk("rx bit", b, rx_seen);
        if (lvl ^ p) chk("partner tx line", 1'(~b), tl);
      end
    end
    give_verdict();
  end
  // Run needs about a thousand cycles; this leaves ample margin
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule // tb
